/* rtl/pif_flags.sv */
// peripheral interrupt enable and request-flag registers on an ahb-lite slave
`include "pif_consts.svh"

module pif_flags (
  input wire logic I_CLOCK, // system clock
  input wire logic I_RST_N, // asynchronous reset, active low
  input wire logic I_CE, // clock enable, freezes state when low
  input wire logic I_HSEL, // ahb slave select
  input wire logic [11:0] I_HADDR, // ahb byte address
  input wire logic [1:0] I_HTRANS, // ahb transfer type
  input wire logic I_HWRITE, // ahb write
  input wire logic [2:0] I_HSIZE, // ahb size
  input wire logic [31:0] I_HWDATA, // ahb write data
  input wire logic I_HREADY, // ahb bus ready
  output logic [31:0] O_HRDATA, // ahb read data
  output logic O_HREADYOUT, // ahb slave ready
  output logic O_HRESP, // ahb response, always okay
  input wire pif_pkg::pif_events_t I_EVENTS, // peripheral event inputs
  output logic O_PERIPH_REQ, // gated peripheral request to core
  output logic O_IRQ // level interrupt from sticky status
);
  import pif_pkg::*;

  pif_state_t s_r;
  pif_state_t s_nxt;
  logic [7:0] set_one;
  logic [7:0] set_two;
  logic [7:0] live_one;
  logic req;
  logic wr_hit;

  // ---------------------------------------------------------------
  // decode helper
  // ---------------------------------------------------------------
  function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
    hit = (a == o);
  endfunction

  // ---------------------------------------------------------------
  // event sources
  // ---------------------------------------------------------------
  always_comb begin
    set_two = {I_EVENTS.osc_fail,
               s_r.cmp_sync[1] != s_r.cmp_seen[1],
               s_r.cmp_sync[0] != s_r.cmp_seen[0],
               I_EVENTS.mem_write_done, 4'h0};
    set_one = {1'b0, I_EVENTS.conv_done, 2'h0,
               I_EVENTS.sync_port_done,
               I_EVENTS.capture_compare,
               I_EVENTS.period_match,
               I_EVENTS.wide_timer_ovf};
    live_one = s_r.flags_one;
    // status flags of the serial port follow its buffer directly
    live_one[`PIF_BIT_RX] = I_EVENTS.rx_full;
    live_one[`PIF_BIT_TX] = I_EVENTS.tx_empty;
  end

  // ---------------------------------------------------------------
  // request to the core
  // ---------------------------------------------------------------
  assign req = s_r.ctrl[0] & s_r.ctrl[1] &
               (|(live_one & s_r.en_one) |
                |(s_r.flags_two & s_r.en_two));

  assign wr_hit = s_r.ph_valid & s_r.ph_write;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.cmp_sync = {I_EVENTS.cmp_two_out, I_EVENTS.cmp_one_out};
    s_nxt.cmp_seen = s_r.cmp_sync;
    if (wr_hit) begin
      // writes: enable bits store, sw flags only clear or set
      if (hit(s_r.ph_addr, `PIF_OFF_EN_ONE)) begin
        s_nxt.en_one = I_HWDATA[7:0] & `PIF_EN_ONE_MASK;
      end
      if (hit(s_r.ph_addr, `PIF_OFF_EN_TWO)) begin
        s_nxt.en_two = I_HWDATA[7:0] & `PIF_EN_TWO_MASK;
      end
      if (hit(s_r.ph_addr, `PIF_OFF_FLAGS_ONE)) begin
        s_nxt.flags_one = I_HWDATA[7:0] & `PIF_F1_SW_MASK;
      end
      if (hit(s_r.ph_addr, `PIF_OFF_FLAGS_TWO)) begin
        s_nxt.flags_two = I_HWDATA[7:0] & `PIF_F2_SW_MASK;
      end
      if (hit(s_r.ph_addr, `PIF_OFF_CTRL)) begin
        s_nxt.ctrl = I_HWDATA[7:0] & `PIF_CTRL_MASK;
      end
      if (hit(s_r.ph_addr, `PIF_OFF_STATUS) && I_HWDATA[0]) begin
        s_nxt.status = 1'b0;
      end
      if (hit(s_r.ph_addr, `PIF_OFF_MASK)) begin
        s_nxt.mask = I_HWDATA[0];
      end
    end
    // events win over a clearing write in the same cycle
    s_nxt.flags_one = s_nxt.flags_one | set_one;
    s_nxt.flags_two = s_nxt.flags_two | set_two;
    if (req) begin
      s_nxt.status = 1'b1;
    end
    // address phase capture
    s_nxt.ph_valid = I_HSEL & I_HREADY & I_HTRANS[1];
    if (I_HREADY) begin
      s_nxt.ph_write = I_HWRITE;
      s_nxt.ph_addr = {I_HADDR[11:2], 2'h0};
    end
    s_nxt.rdata = 32'h0000_0000;
    if (I_HSEL & I_HREADY & I_HTRANS[1] & ~I_HWRITE) begin
      unique case ({I_HADDR[11:2], 2'h0})
        `PIF_OFF_EN_ONE: s_nxt.rdata[7:0] = s_r.en_one;
        `PIF_OFF_EN_TWO: s_nxt.rdata[7:0] = s_r.en_two;
        `PIF_OFF_FLAGS_ONE: s_nxt.rdata[7:0] = live_one;
        `PIF_OFF_FLAGS_TWO: s_nxt.rdata[7:0] = s_r.flags_two;
        `PIF_OFF_CTRL: s_nxt.rdata[7:0] = s_r.ctrl;
        `PIF_OFF_STATUS: s_nxt.rdata[0] = s_r.status;
        `PIF_OFF_MASK: s_nxt.rdata[0] = s_r.mask;
        default: s_nxt.rdata = 32'h0000_0000;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      s_r <= '0;
    end else if (I_CE) begin
      s_r <= s_nxt;
    end
  end

  assign O_HRDATA = s_r.rdata;
  assign O_HREADYOUT = 1'b1;
  assign O_HRESP = 1'b0;
  assign O_PERIPH_REQ = req;
  assign O_IRQ = s_r.status & s_r.mask;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (!I_RST_N);

  sequence ce_event_conv;
    I_CE && I_EVENTS.conv_done;
  endsequence

  a_req_needs_master: assert property (O_PERIPH_REQ |-> s_r.ctrl[1])
    else $error("request without master enable");
  a_conv_flag_set: assert property (ce_event_conv |=> s_r.flags_one[6])
    else $error("conversion flag not set");
  a_ovf_flag_set: assert property (I_CE && I_EVENTS.wide_timer_ovf |=> s_r.flags_one[0])
    else $error("overflow flag not set");
  a_en_two_low: assert property (s_r.en_two[3:0] == 4'h0)
    else $error("enable two low bits set");
  a_rx_mirror: assert property (live_one[5] == I_EVENTS.rx_full)
    else $error("receive flag not mirrored");
  a_tx_mirror: assert property (live_one[4] == I_EVENTS.tx_empty)
    else $error("transmit flag not mirrored");
  a_osc_flag_set: assert property (I_CE && I_EVENTS.osc_fail |=> s_r.flags_two[7])
    else $error("osc fail flag not set");
  a_period_set: assert property (I_CE && I_EVENTS.period_match |=> s_r.flags_one[1])
    else $error("period flag not set");
  a_mem_wr_set: assert property (I_CE && I_EVENTS.mem_write_done |=> s_r.flags_two[4])
    else $error("write done flag not set");
  a_sync_set: assert property (I_CE && I_EVENTS.sync_port_done |=> s_r.flags_one[3])
    else $error("sync port flag not set");
  a_ccp_set: assert property (I_CE && I_EVENTS.capture_compare |=> s_r.flags_one[2])
    else $error("capture flag not set");
  a_cmp_edge: assert property (I_CE && s_r.cmp_sync[0] != s_r.cmp_seen[0] |=> s_r.flags_two[5])
    else $error("comparator flag not set");
  a_req_or: assert property (s_r.ctrl == 8'h03 && |(s_r.flags_two & s_r.en_two) |-> O_PERIPH_REQ)
    else $error("enabled flag gives no request");
  a_set_wins: assert property (I_CE && I_EVENTS.conv_done && wr_hit |=> s_r.flags_one[6])
    else $error("clear beat a set");
  a_en_reset: assert property ($rose(I_RST_N) |-> s_r.en_one == 8'h00)
    else $error("enable not clear after reset");
  a_flag_sticky: assert property (I_CE && s_r.flags_one[0] && !wr_hit |=> s_r.flags_one[0])
    else $error("flag dropped without write");
endmodule

/* rtl/pif_consts.svh */
// register offsets, field positions and reset values of the flag block
`ifndef PIF_CONSTS_SVH
`define PIF_CONSTS_SVH
`define PIF_OFF_EN_ONE 12'h000
`define PIF_OFF_EN_TWO 12'h004
`define PIF_OFF_FLAGS_ONE 12'h008
`define PIF_OFF_FLAGS_TWO 12'h00C
`define PIF_OFF_CTRL 12'h010
`define PIF_OFF_STATUS 12'h014
`define PIF_OFF_MASK 12'h018
`define PIF_EN_TWO_MASK 8'hF0
`define PIF_EN_ONE_MASK 8'h7F
`define PIF_F1_SW_MASK 8'h4F
`define PIF_F2_SW_MASK 8'hF0
`define PIF_BIT_RX 5
`define PIF_BIT_TX 4
`define PIF_CTRL_MASK 8'h03
`define PIF_RST_BYTE 8'h00
`define PIF_HTRANS_NONSEQ 2'h2
`define PIF_HSIZE_WORD 3'h2
`endif

/* rtl/pif_pkg.sv */
// types shared by the peripheral interrupt flag block
package pif_pkg;
  typedef struct packed {
    logic osc_fail;
    logic cmp_two_out;
    logic cmp_one_out;
    logic mem_write_done;
    logic conv_done;
    logic rx_full;
    logic tx_empty;
    logic sync_port_done;
    logic capture_compare;
    logic period_match;
    logic wide_timer_ovf;
  } pif_events_t;

  typedef struct packed {
    logic [7:0] en_one;
    logic [7:0] en_two;
    logic [7:0] flags_one;
    logic [7:0] flags_two;
    logic [7:0] ctrl;
    logic [1:0] cmp_sync;
    logic [1:0] cmp_seen;
    logic status;
    logic mask;
    logic ph_valid;
    logic ph_write;
    logic [11:0] ph_addr;
    logic [31:0] rdata;
  } pif_state_t;
endpackage

/* test/pif_periph_model.sv */
// ----------------------------------------------------------
// peripheral event source model for the flag block
// ----------------------------------------------------------
module pif_periph_model (
  input wire logic i_clk, // system clock
  input wire logic [10:0] i_fire, // event request, held one cycle
  input wire logic [3:0] i_lvl, // cmp two, cmp one, rx full, tx empty
  output pif_pkg::pif_events_t o_ev // events to the block
);
  timeunit 1ns;
  timeprecision 1ps;
  import pif_pkg::*;
  logic [10:0] p_r;
  // events are one-cycle pulses, launched from a clock edge
  always_ff @(posedge i_clk) begin
    p_r <= i_fire;
  end
  assign o_ev = {p_r[10], i_lvl[3:2], p_r[7:6], i_lvl[1:0], p_r[3:0]};
endmodule

/* test/pif_flags_tb_top.sv */
// ----------------------------------------------------------
// self-checking bench for the peripheral flag block
// ----------------------------------------------------------
`include "pif_consts.svh"
module pif_flags_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import pif_pkg::*;
  logic clk = 0, rst_n = 0, hsel = 0, hwr = 0, rdy, resp, req, irq;
  logic [11:0] ha = 0;
  logic [1:0] htr = 0;
  logic [31:0] hwd = 0, hrd, rd;
  logic [10:0] fire = 0;
  logic [3:0] lvl = 0;
  pif_events_t ev;
  int n_mismatch = 0, total_checks = 0;
  always #5 clk = ~clk;
  pif_periph_model pm_u (.i_clk(clk), .i_fire(fire), .i_lvl(lvl),
    .o_ev(ev));
  pif_flags dut_u (.I_CLOCK(clk), .I_RST_N(rst_n), .I_CE(1'b1),
    .I_HSEL(hsel), .I_HADDR(ha), .I_HTRANS(htr), .I_HWRITE(hwr),
    .I_HSIZE(`PIF_HSIZE_WORD), .I_HWDATA(hwd), .I_HREADY(rdy),
    .O_HRDATA(hrd), .O_HREADYOUT(rdy), .O_HRESP(resp),
    .I_EVENTS(ev), .O_PERIPH_REQ(req), .O_IRQ(irq));
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // entered just after a rising edge; leaves at the data-phase edge
  task automatic xfer(logic w, logic [11:0] a, logic [31:0] d);
    hsel <= 1'b1;
    htr <= `PIF_HTRANS_NONSEQ;
    ha <= a;
    hwr <= w;
    do @(posedge clk); while (rdy !== 1'b1);
    htr <= 2'h0;
    hwd <= d;
    do @(posedge clk); while (rdy !== 1'b1);
    rd = hrd;
  endtask
  task automatic rdc(string nm, logic [11:0] a, logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask
  task automatic pulse(logic [10:0] f);
    fire <= f;
    @(posedge clk);
    fire <= 11'h000;
    repeat (3) @(posedge clk);
  endtask
  task automatic settle_chk(string nm, logic e, logic g_sel);
    repeat (2) @(posedge clk);
    chk(nm, {31'h0, e}, {31'h0, g_sel ? irq : req});
  endtask
  task automatic clr_flags();
    xfer(1'b1, `PIF_OFF_FLAGS_ONE, 32'h0);
    xfer(1'b1, `PIF_OFF_FLAGS_TWO, 32'h0);
  endtask
  task automatic t_reset();
    for (int a = 0; a < 32; a += 4)
      rdc("reset value", a[11:0], 32'h0);
    settle_chk("req at reset", 1'b0, 1'b0);
    $display("t_reset done");
  endtask
  task automatic t_en_two();
    xfer(1'b1, `PIF_OFF_EN_TWO, 32'hFFFFFFFF);
    rdc("enable two", `PIF_OFF_EN_TWO, 32'h000000F0);
    xfer(1'b1, `PIF_OFF_EN_TWO, 32'h0);
    rdc("enable two", `PIF_OFF_EN_TWO, 32'h0);
    $display("t_en_two done");
  endtask
  task automatic t_events();
    int src[7] = '{10, 7, 6, 3, 2, 1, 0};
    logic [10:0] f;
    foreach (src[i]) begin
      f = 11'h001 << src[i];
      pulse(f);
      rdc("flags one", `PIF_OFF_FLAGS_ONE, {25'h0, f[6:0]});
      rdc("flags two", `PIF_OFF_FLAGS_TWO, {24'h0, f[10:7], 4'h0});
      clr_flags();
      rdc("cleared", `PIF_OFF_FLAGS_ONE, 32'h0);
    end
    lvl <= 4'h3;
    xfer(1'b1, `PIF_OFF_FLAGS_ONE, 32'h0);
    rdc("live rx tx", `PIF_OFF_FLAGS_ONE, 32'h30);
    lvl <= 4'h0;
    xfer(1'b1, `PIF_OFF_FLAGS_ONE, 32'hFF);
    rdc("set by write", `PIF_OFF_FLAGS_ONE, 32'h4F);
    clr_flags();
    $display("t_events done");
  endtask
  task automatic t_cmp();
    logic [3:0] lv[3] = '{4'h4, 4'hC, 4'h0};
    logic [31:0] ex[3] = '{32'h20, 32'h40, 32'h60};
    foreach (lv[i]) begin
      lvl <= lv[i];
      repeat (4) @(posedge clk);
      rdc("comparator flag", `PIF_OFF_FLAGS_TWO, ex[i]);
      clr_flags();
    end
    $display("t_cmp done");
  endtask
  task automatic t_gate();
    // flag is clear before the source is enabled
    clr_flags();
    xfer(1'b1, `PIF_OFF_EN_ONE, 32'h1);
    xfer(1'b1, `PIF_OFF_CTRL, 32'h1);
    pulse(11'h001);
    settle_chk("no master", 1'b0, 1'b0);
    xfer(1'b1, `PIF_OFF_CTRL, 32'h3);
    settle_chk("request", 1'b1, 1'b0);
    xfer(1'b1, `PIF_OFF_EN_ONE, 32'h0);
    settle_chk("disabled", 1'b0, 1'b0);
    xfer(1'b1, `PIF_OFF_EN_ONE, 32'h1);
    xfer(1'b1, `PIF_OFF_CTRL, 32'h2);
    settle_chk("no global", 1'b0, 1'b0);
    xfer(1'b1, `PIF_OFF_MASK, 32'h1);
    xfer(1'b1, `PIF_OFF_CTRL, 32'h3);
    settle_chk("irq", 1'b1, 1'b1);
    rdc("status", `PIF_OFF_STATUS, 32'h1);
    xfer(1'b1, `PIF_OFF_CTRL, 32'h0);
    xfer(1'b1, `PIF_OFF_STATUS, 32'h1);
    settle_chk("irq cleared", 1'b0, 1'b1);
    xfer(1'b1, 12'h100, 32'hFF);
    rdc("unmapped", 12'h100, 32'h0);
    $display("t_gate done");
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    complete_run();
  end
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_en_two();
    t_events();
    t_cmp();
    t_gate();
    complete_run();
  end
endmodule
